// ===== rtl/rsp_pkg.sv
// regulator setpoint/limit register bank: shared constants and carriers
// assumes an 8-bit addressed serial control port decoded upstream
`default_nettype none
package rsp_pkg;
	localparam int          DW           = 8;
	localparam int          CW           = 6;
	localparam logic [7:0]  OFF_CEIL1    = 8'h12;
	localparam logic [7:0]  OFF_OP2      = 8'h13;
	localparam logic [7:0]  OFF_ALT2     = 8'h14;
	localparam int          POS_SRC      = 6;
	localparam int          POS_ENABLE   = 7;
	localparam int          POS_PWRSAVE  = 6;
	localparam logic [5:0]  CEIL_OPEN_LO = 6'h00;
	localparam logic [5:0]  CEIL_OPEN_HI = 6'h3F;
	localparam logic [7:0]  RDATA_RESET  = 8'h00;
	localparam logic [7:0]  RDATA_UNMAP  = 8'h00;
	localparam logic [1:0]  RSVD_ZERO2   = 2'h0;
	localparam logic        RSVD_ZERO1   = 1'h0;

	// one register port request
	typedef struct packed {
		logic          wr;
		logic          rd;
		logic [7:0]    addr;
		logic [DW-1:0] wdata;
	} rsp_req_t;

	// one-time-programmed defaults, static while running
	typedef struct packed {
		logic [CW-1:0] ceiling;
		logic          op_src;
		logic [CW-1:0] op_code;
		logic          alt_enable;
		logic          alt_pwrsave;
		logic [CW-1:0] alt_code;
	} rsp_otp_t;

	// regulator control outputs
	typedef struct packed {
		logic [CW-1:0] code;
		logic          enable;
		logic          pwrsave;
		logic [CW-1:0] ceiling;
	} rsp_ctl_t;
endpackage
`default_nettype wire

// ===== rtl/rsp_regs.sv
// regulator setpoint/limit register bank: ceiling, operating and alternate setpoints
// assumes the serial port front end delivers one-cycle wr/rd strobes on i_clk
//
// Contract
// - ceiling field caps both setpoint codes at write time
// - over-ceiling setpoint codes are discarded
// - intermediate ceiling locks whole limit register
// - reserved bits read zero, written zero
// - source select picks operating or alternate code
// - setpoints hold six-bit voltage codes
// - alternate bit7 enables the regulator
// - alternate bit6 selects power-save mode
// - reset reloads one-time-programmed defaults
`timescale 1ns/10ps
`default_nettype none
module rsp_regs (
	input  wire logic              i_clk,
	input  wire logic              i_reset_n,
	input  wire rsp_pkg::rsp_req_t i_req,
	input  wire rsp_pkg::rsp_otp_t i_otp,
	output logic [7:0]             o_rdata,
	output var rsp_pkg::rsp_ctl_t  o_ctl
);
	logic [5:0] ceil_r,     ceil_nxt;
	logic       src_r,      src_nxt;
	logic [5:0] op_code_r,  op_code_nxt;
	logic       en_r,       en_nxt;
	logic       psave_r,    psave_nxt;
	logic [5:0] alt_code_r, alt_code_nxt;
	logic [7:0] rdata_r,    rdata_nxt;
	rsp_pkg::rsp_ctl_t ctl_r, ctl_nxt;
	logic       locked;
	logic [5:0] wcode;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	// unsigned compare, done on the incoming code before storage
	function automatic logic code_ok(input logic [5:0] c, input logic [5:0] lim);
		code_ok = (c <= lim);
	endfunction

	// 0x00 and 0x3F leave the register writable; anything else freezes it
	assign locked = (ceil_r != rsp_pkg::CEIL_OPEN_LO) && (ceil_r != rsp_pkg::CEIL_OPEN_HI);
	assign wcode  = i_req.wdata[5:0];

	always_comb begin
		ceil_nxt     = ceil_r;
		src_nxt      = src_r;
		op_code_nxt  = op_code_r;
		en_nxt       = en_r;
		psave_nxt    = psave_r;
		alt_code_nxt = alt_code_r;
		// defaults copied on every clock edge while reset is low, so i_otp must settle before release
		if (!i_reset_n) begin
			ceil_nxt     = i_otp.ceiling;
			src_nxt      = i_otp.op_src;
			op_code_nxt  = i_otp.op_code;
			en_nxt       = i_otp.alt_enable;
			psave_nxt    = i_otp.alt_pwrsave;
			alt_code_nxt = i_otp.alt_code;
		end else if (i_req.wr) begin
			if (hit(i_req.addr, rsp_pkg::OFF_CEIL1)) begin
				if (!locked) begin
					ceil_nxt = wcode;
				end
			end else if (hit(i_req.addr, rsp_pkg::OFF_OP2)) begin
				src_nxt = i_req.wdata[rsp_pkg::POS_SRC];
				// over-limit code dropped, control bits still taken
				if (code_ok(wcode, ceil_r)) begin
					op_code_nxt = wcode;
				end
			end else if (hit(i_req.addr, rsp_pkg::OFF_ALT2)) begin
				en_nxt    = i_req.wdata[rsp_pkg::POS_ENABLE];
				psave_nxt = i_req.wdata[rsp_pkg::POS_PWRSAVE];
				if (code_ok(wcode, ceil_r)) begin
					alt_code_nxt = wcode;
				end
			end
		end
	end

	always_ff @(posedge i_clk) begin
		ceil_r     <= ceil_nxt;
		src_r      <= src_nxt;
		op_code_r  <= op_code_nxt;
		en_r       <= en_nxt;
		psave_r    <= psave_nxt;
		alt_code_r <= alt_code_nxt;
	end

	// read data held until the next read or reset; bit 7 of op and 7:6 of limit fixed low
	always_comb begin
		rdata_nxt = rdata_r;
		if (!i_reset_n) begin
			rdata_nxt = rsp_pkg::RDATA_RESET;
		end else if (i_req.rd) begin
			if (hit(i_req.addr, rsp_pkg::OFF_CEIL1)) begin
				rdata_nxt = {rsp_pkg::RSVD_ZERO2, ceil_r};
			end else if (hit(i_req.addr, rsp_pkg::OFF_OP2)) begin
				rdata_nxt = {rsp_pkg::RSVD_ZERO1, src_r, op_code_r};
			end else if (hit(i_req.addr, rsp_pkg::OFF_ALT2)) begin
				rdata_nxt = {en_r, psave_r, alt_code_r};
			end else begin
				rdata_nxt = rsp_pkg::RDATA_UNMAP;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		rdata_r <= rdata_nxt;
	end

	// outputs lag the registers by one cycle so they come straight from flops
	always_comb begin
		ctl_nxt.code    = src_r ? alt_code_r : op_code_r;
		ctl_nxt.enable  = en_r;
		ctl_nxt.pwrsave = psave_r;
		ctl_nxt.ceiling = ceil_r;
	end

	always_ff @(posedge i_clk) begin
		ctl_r <= ctl_nxt;
	end

	assign o_rdata = rdata_r;
	assign o_ctl   = ctl_r;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	reject_write_a: assert property (
		i_req.wr && hit(i_req.addr, rsp_pkg::OFF_OP2) && (wcode > ceil_r)
		|=> $stable(op_code_r))
		else $error("over-ceiling operating code was stored");

	accept_alt_a: assert property (
		i_req.wr && hit(i_req.addr, rsp_pkg::OFF_ALT2) && (wcode <= ceil_r)
		|=> alt_code_r == $past(wcode))
		else $error("in-range alternate code not stored");

	ceil_lock_a: assert property (
		locked |=> locked && $stable(ceil_r))
		else $error("locked ceiling changed");

	ceil_write_a: assert property (
		i_req.wr && hit(i_req.addr, rsp_pkg::OFF_CEIL1) && !locked
		|=> ceil_r == $past(wcode) ##1 o_ctl.ceiling == $past(wcode, 2))
		else $error("open ceiling write not applied");

	rsvd_read_a: assert property (
		i_req.rd && hit(i_req.addr, rsp_pkg::OFF_CEIL1)
		|=> o_rdata == {2'h0, $past(ceil_r)})
		else $error("limit read-back wrong or reserved bits nonzero");

	source_sel_a: assert property (
		src_r && i_req.wr == 1'h0 ##1 i_req.wr == 1'h0 |=> o_ctl.code == $past(alt_code_r, 2))
		else $error("alternate source not driving code");

	enable_out_a: assert property (
		i_req.wr && hit(i_req.addr, rsp_pkg::OFF_ALT2)
		|=> ##1 o_ctl.enable == $past(i_req.wdata[7], 2))
		else $error("enable output does not follow bit 7");

	pwrsave_out_a: assert property (
		i_req.wr && hit(i_req.addr, rsp_pkg::OFF_ALT2)
		|=> ##1 o_ctl.pwrsave == $past(i_req.wdata[6], 2))
		else $error("power-save output does not follow bit 6");

	reset_load_a: assert property (
		$rose(i_reset_n) |-> ceil_r == $past(i_otp.ceiling) && op_code_r == $past(i_otp.op_code))
		else $error("defaults not loaded at reset");

	// a dropped code must leave the stored one untouched, on both setpoints
	reject_alt_a: assert property (
		i_req.wr && hit(i_req.addr, rsp_pkg::OFF_ALT2) && (wcode > ceil_r)
		|=> $stable(alt_code_r))
		else $error("over-ceiling alternate code was stored");

	accept_op_a: assert property (
		i_req.wr && hit(i_req.addr, rsp_pkg::OFF_OP2) && (wcode <= ceil_r)
		|=> op_code_r == $past(wcode))
		else $error("in-range operating code not stored");

	op_cap_a: assert property (
		i_req.wr && hit(i_req.addr, rsp_pkg::OFF_OP2)
		|=> (op_code_r <= $past(ceil_r)) || $stable(op_code_r))
		else $error("operating code stored above ceiling");

	alt_cap_a: assert property (
		i_req.wr && hit(i_req.addr, rsp_pkg::OFF_ALT2)
		|=> (alt_code_r <= $past(ceil_r)) || $stable(alt_code_r))
		else $error("alternate code stored above ceiling");

	src_write_a: assert property (
		i_req.wr && hit(i_req.addr, rsp_pkg::OFF_OP2)
		|=> src_r == $past(i_req.wdata[rsp_pkg::POS_SRC]))
		else $error("source select bit not taken");

	source_op_a: assert property (
		!src_r && i_req.wr == 1'h0 ##1 i_req.wr == 1'h0 |=> o_ctl.code == $past(op_code_r, 2))
		else $error("operating source not driving code");

	// a locked ceiling is only undone by reset, which the disable covers
	locked_write_a: assert property (
		i_req.wr && hit(i_req.addr, rsp_pkg::OFF_CEIL1) && locked
		|=> $stable(ceil_r))
		else $error("write to locked ceiling applied");

	op_read_a: assert property (
		i_req.rd && hit(i_req.addr, rsp_pkg::OFF_OP2)
		|=> o_rdata == {1'h0, $past(src_r), $past(op_code_r)})
		else $error("operating read-back wrong or bit 7 nonzero");

	alt_read_a: assert property (
		i_req.rd && hit(i_req.addr, rsp_pkg::OFF_ALT2)
		|=> o_rdata == {$past(en_r), $past(psave_r), $past(alt_code_r)})
		else $error("alternate read-back wrong");

	// outside reset, nothing but a write may move the ceiling or either stored code
	idle_hold_a: assert property (
		!i_req.wr |=> $stable(ceil_r) && $stable(op_code_r) && $stable(alt_code_r))
		else $error("stored field changed without a write");
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
// bench for the regulator setpoint/limit bank: table rows, then reset and lock cases
// assumes rtl/rsp_pkg.sv and rtl/rsp_regs.sv are compiled first
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	typedef struct packed {
		logic [7:0]        addr;
		logic [7:0]        wdata;
		logic [7:0]        rdata;
		rsp_pkg::rsp_ctl_t ctl;
	} rsp_row_t;
	logic              i_clk;
	logic              i_reset_n;
	rsp_pkg::rsp_req_t i_req;
	rsp_pkg::rsp_otp_t i_otp;
	logic [7:0]        o_rdata;
	rsp_pkg::rsp_ctl_t o_ctl;
	int                fail_count;
	int                checked;
	int                cycles;
	rsp_row_t          rows [4];
	rsp_regs dut (
		.i_clk     (i_clk),
		.i_reset_n (i_reset_n),
		.i_req     (i_req),
		.i_otp     (i_otp),
		.o_rdata   (o_rdata),
		.o_ctl     (o_ctl)
	);
	task automatic chk(input string name, input logic [13:0] exp, input logic [13:0] got);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_req <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
		@(posedge i_clk);
		i_req.wr <= 1'h0;
	endtask
	// o_ctl has settled by the time the read answer is sampled
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge i_clk);
		i_req <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
		@(posedge i_clk);
		i_req.rd <= 1'h0;
		@(negedge i_clk);
		chk("rdata", {6'h00, e}, {6'h00, o_rdata});
	endtask
	task automatic complete_run;
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		i_clk = 1'h0;
		forever #50 i_clk = ~i_clk;
	end
	// whole run is well under a thousand cycles
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 2000) begin
			fail_count++;
			complete_run();
		end
	end
	initial begin
		fail_count = 0;
		checked = 0;
		cycles = 0;
		i_reset_n = 1'h0;
		i_req = '0;
		i_otp = '{6'h3F, 1'h0, 6'h02, 1'h1, 1'h0, 6'h04};
		rows[0] = '{8'h13, 8'h45, 8'h45, '{6'h04, 1'h1, 1'h0, 6'h3F}};
		rows[1] = '{8'h14, 8'hC7, 8'hC7, '{6'h07, 1'h1, 1'h1, 6'h3F}};
		rows[2] = '{8'h14, 8'h03, 8'h03, '{6'h03, 1'h0, 1'h0, 6'h3F}};
		rows[3] = '{8'h13, 8'h10, 8'h10, '{6'h10, 1'h0, 1'h0, 6'h3F}};
		repeat (16) @(posedge i_clk);
		i_reset_n <= 1'h1;
		rd(8'h12, 8'h3F);
		rd(8'h13, 8'h02);
		rd(8'h14, 8'h84);
		chk("ctl", {6'h02, 1'h1, 1'h0, 6'h3F}, o_ctl);
		foreach (rows[i]) begin
			wr(rows[i].addr, rows[i].wdata);
			rd(rows[i].addr, rows[i].rdata);
			chk("ctl", rows[i].ctl, o_ctl);
		end
		wr(8'h12, 8'h00);
		rd(8'h12, 8'h00);
		wr(8'h13, 8'h01);
		rd(8'h13, 8'h10);
		wr(8'h12, 8'h20);
		rd(8'h12, 8'h20);
		wr(8'h12, 8'h3F);
		rd(8'h12, 8'h20);
		wr(8'h14, 8'h61);
		rd(8'h14, 8'h43);
		wr(8'h14, 8'hA0);
		rd(8'h14, 8'hA0);
		chk("ctl", {6'h10, 1'h1, 1'h0, 6'h20}, o_ctl);
		wr(8'h13, 8'h7F);
		rd(8'h13, 8'h50);
		chk("ctl", {6'h20, 1'h1, 1'h0, 6'h20}, o_ctl);
		rd(8'h15, 8'h00);
		@(posedge i_clk);
		i_reset_n <= 1'h0;
		// second variant of defaults, swapped in while reset is held
		i_otp     <= '{6'h05, 1'h1, 6'h02, 1'h0, 1'h1, 6'h04};
		repeat (2) @(posedge i_clk);
		i_reset_n <= 1'h1;
		@(negedge i_clk);
		chk("ctl", {6'h04, 1'h0, 1'h1, 6'h05}, o_ctl);
		rd(8'h12, 8'h05);
		rd(8'h13, 8'h42);
		rd(8'h14, 8'h44);
		wr(8'h12, 8'h3F);
		rd(8'h12, 8'h05);
		wr(8'h14, 8'h86);
		rd(8'h14, 8'h84);
		chk("ctl", {6'h04, 1'h1, 1'h0, 6'h05}, o_ctl);
		complete_run();
	end
endmodule
`default_nettype wire
